// ===== ipl_dev_end.sv
// Device node: register-driven write control with token arbitration
`timescale 1ns/1ps
`include "ipl_defs.svh"
module ipl_dev_end #(
  parameter int CHANNELS    = `IPL_CHAN_MAX,
  parameter int ACK_TIMEOUT = `IPL_ACK_TIMEOUT_CYC,
  parameter bit INIT_TOKEN  = 1'b1
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  // Interrupt
  output logic             o_irq,
  // Link
  ipl_link_if.dev          link
);

  if (CHANNELS < 1 || CHANNELS > `IPL_CHAN_MAX) begin : g_chk_ch
    $error("ipl_dev_end: CHANNELS must be 1 to 4");
  end
  if (ACK_TIMEOUT < 2 || ACK_TIMEOUT >= (1 << `IPL_TMO_W)) begin : g_chk_to
    $error("ipl_dev_end: ACK_TIMEOUT out of range");
  end

  localparam int CW = CHANNELS;

  function automatic logic [CW-1:0] chan_bit(input logic [1:0] c);
    logic [CW-1:0] m;
    m = '0;
    for (int i = 0; i < CW; i++) begin
      m[i] = (c == 2'(i));
    end
    return m;
  endfunction

  function automatic logic [1:0] lowest(input logic [CW-1:0] m);
    logic [1:0] c;
    c = 2'h0;
    for (int i = CW - 1; i >= 0; i--) begin
      if (m[i]) begin
        c = 2'(i);
      end
    end
    return c;
  endfunction

  ipl_pkg::node_state_e  state_r;
  ipl_pkg::node_state_e  state_nxt;
  logic                  req_valid_r;
  logic                  req_stream_r;
  logic [1:0]            req_chan_r;
  logic [1:0]            out_chan_r;
  logic [7:0]            tx_data_r;
  logic [`IPL_TMO_W-1:0] tmo_cnt_r;
  logic [CW-1:0]         ack_rcv_r;
  logic [CW-1:0]         toe_r;
  logic [CW-1:0]         write_ack_irq_enable_r;
  logic [CW-1:0]         toe_ie_r;
  logic [7:0]            rx_data_r;
  logic [1:0]            rx_chan_r;
  logic                  rx_stream_r;
  logic                  tx_valid_nxt;
  ipl_pkg::frame_kind_e  tx_kind_nxt;
  logic [1:0]            tx_chan_nxt;
  logic [7:0]            tx_data_nxt;
  logic                  send_req;
  logic                  ack_evt;
  logic                  tmo_evt;
  logic                  rx_wr;
  logic                  rx_trig;
  logic                  rx_ack;
  logic                  cmd_wr;
  logic [CW-1:0]         cmd_wrt;
  logic [CW-1:0]         cmd_st;
  logic [CW-1:0]         cmd_any;
  logic [1:0]            cmd_chan;
  logic                  can_take;
  logic                  take;
  logic [CW-1:0]         refused;
  logic [CW-1:0]         ack_set;
  logic [CW-1:0]         toe_set;
  logic [31:0]           rd_word;

  assign rx_wr   = link.p2d_valid && (link.p2d_kind == ipl_pkg::FK_WRITE ||
                                      link.p2d_kind == ipl_pkg::FK_STREAM);
  assign rx_trig = link.p2d_valid && link.p2d_kind == ipl_pkg::FK_TRIGGER;
  assign rx_ack  = link.p2d_valid && link.p2d_kind == ipl_pkg::FK_ACK;

  // Command decode; write start wins over stream start on one channel
  assign cmd_wr   = i_wr && i_addr == `IPL_REG_CMD;
  assign cmd_wrt  = cmd_wr ? i_wdata[`IPL_CMD_WRT_LSB +: CW] : '0;
  assign cmd_st   = cmd_wr ? i_wdata[`IPL_CMD_ST_LSB +: CW] : '0;
  assign cmd_any  = cmd_wrt | cmd_st;
  assign cmd_chan = lowest(cmd_any);

  // A start is taken only with nothing queued and no ack outstanding
  assign can_take = !req_valid_r && state_r != ipl_pkg::S_WAIT_ACK;
  assign take     = can_take && |cmd_any;
  // Refusing instead of sending keeps the earlier frame's last byte intact
  assign refused  = can_take ? (cmd_any & ~chan_bit(cmd_chan))
                             : cmd_any;

  always_comb begin
    state_nxt    = state_r;
    tx_valid_nxt = 1'b0;
    tx_kind_nxt  = ipl_pkg::FK_TRIGGER;
    tx_chan_nxt  = 2'h0;
    tx_data_nxt  = 8'h00;
    send_req     = 1'b0;
    ack_evt      = 1'b0;
    tmo_evt      = 1'b0;
    if (rx_wr) begin
      // Peer only writes while it holds the token, so no clash here
      tx_valid_nxt = 1'b1;
      tx_kind_nxt  = ipl_pkg::FK_ACK;
      tx_chan_nxt  = link.p2d_chan;
    end else begin
      case (state_r)
        ipl_pkg::S_HOLD, ipl_pkg::S_NO_TOKEN: begin
          if (state_r == ipl_pkg::S_HOLD || rx_trig) begin
            tx_valid_nxt = 1'b1;
            if (req_valid_r) begin
              tx_kind_nxt = req_stream_r ? ipl_pkg::FK_STREAM
                                         : ipl_pkg::FK_WRITE;
              tx_chan_nxt = req_chan_r;
              tx_data_nxt = tx_data_r;
              send_req    = 1'b1;
              state_nxt   = ipl_pkg::S_WAIT_ACK;
            end else begin
              state_nxt   = ipl_pkg::S_NO_TOKEN;
            end
          end
        end
        ipl_pkg::S_WAIT_ACK: begin
          if (rx_ack && link.p2d_chan == out_chan_r) begin
            ack_evt      = 1'b1;
            tx_valid_nxt = 1'b1;
            state_nxt    = ipl_pkg::S_NO_TOKEN;
          end else if (tmo_cnt_r == `IPL_TMO_W'(ACK_TIMEOUT - 1)) begin
            tmo_evt      = 1'b1;
            tx_valid_nxt = 1'b1;
            state_nxt    = ipl_pkg::S_NO_TOKEN;
          end
        end
        default: state_nxt = ipl_pkg::S_NO_TOKEN;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_r <= INIT_TOKEN ? ipl_pkg::S_HOLD : ipl_pkg::S_NO_TOKEN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Queued request, one deep
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      req_valid_r  <= 1'b0;
      req_stream_r <= 1'b0;
      req_chan_r   <= 2'h0;
      out_chan_r   <= 2'h0;
    end else begin
      if (send_req) begin
        req_valid_r <= 1'b0;
        out_chan_r  <= req_chan_r;
      end else if (take) begin
        req_valid_r  <= 1'b1;
        req_stream_r <= !(|(cmd_wrt & chan_bit(cmd_chan)));
        req_chan_r   <= cmd_chan;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst || state_r != ipl_pkg::S_WAIT_ACK) begin
      tmo_cnt_r <= '0;
    end else begin
      tmo_cnt_r <= tmo_cnt_r + `IPL_TMO_W'(1);
    end
  end

  // Sticky flags; a set in the clearing read's cycle survives it
  assign ack_set = ack_evt ? chan_bit(out_chan_r) : '0;
  assign toe_set = refused | (tmo_evt ? chan_bit(out_chan_r) : '0);

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ack_rcv_r <= '0;
    end else if (i_rd && i_addr == `IPL_REG_STATUS) begin
      ack_rcv_r <= ack_set;
    end else begin
      ack_rcv_r <= ack_rcv_r | ack_set;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      toe_r <= '0;
    end else if (i_rd && i_addr == `IPL_REG_ERROR) begin
      toe_r <= toe_set;
    end else begin
      toe_r <= toe_r | toe_set;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      tx_data_r <= `IPL_TXDATA_RST;
      write_ack_irq_enable_r    <= CW'(`IPL_IRQEN_RST);
      toe_ie_r  <= CW'(`IPL_IRQEN_RST);
    end else if (i_wr && i_addr == `IPL_REG_TXDATA) begin
      tx_data_r <= i_wdata[7:0];
    end else if (i_wr && i_addr == `IPL_REG_IRQEN) begin
      write_ack_irq_enable_r   <= i_wdata[`IPL_IRQEN_WRITE_ACK_IRQ_ENABLE_LSB +: CW];
      toe_ie_r <= i_wdata[`IPL_IRQEN_TOE_LSB +: CW];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rx_data_r   <= 8'h00;
      rx_chan_r   <= 2'h0;
      rx_stream_r <= 1'b0;
    end else if (rx_wr) begin
      rx_data_r   <= link.p2d_data;
      rx_chan_r   <= link.p2d_chan;
      rx_stream_r <= link.p2d_kind == ipl_pkg::FK_STREAM;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      link.d2p_valid <= 1'b0;
      link.d2p_kind  <= ipl_pkg::FK_TRIGGER;
      link.d2p_chan  <= 2'h0;
      link.d2p_data  <= 8'h00;
    end else begin
      link.d2p_valid <= tx_valid_nxt;
      link.d2p_kind  <= tx_kind_nxt;
      link.d2p_chan  <= tx_chan_nxt;
      link.d2p_data  <= tx_data_nxt;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (i_addr)
      `IPL_REG_CMD: begin
        if (state_r == ipl_pkg::S_WAIT_ACK) begin
          rd_word[`IPL_CMD_WRT_LSB +: CW] = chan_bit(out_chan_r);
        end
        rd_word[`IPL_CMD_PEND_BIT]  = req_valid_r;
        rd_word[`IPL_CMD_TOKEN_BIT] = state_r != ipl_pkg::S_NO_TOKEN;
        rd_word[`IPL_CMD_WAIT_BIT]  = state_r == ipl_pkg::S_WAIT_ACK;
      end
      `IPL_REG_TXDATA: rd_word[7:0] = tx_data_r;
      `IPL_REG_STATUS: rd_word[CW-1:0] = ack_rcv_r;
      `IPL_REG_ERROR:  rd_word[CW-1:0] = toe_r;
      `IPL_REG_IRQEN: begin
        rd_word[`IPL_IRQEN_WRITE_ACK_IRQ_ENABLE_LSB +: CW] = write_ack_irq_enable_r;
        rd_word[`IPL_IRQEN_TOE_LSB +: CW]  = toe_ie_r;
      end
      `IPL_REG_RXDATA: begin
        rd_word[7:0]                       = rx_data_r;
        rd_word[`IPL_RX_CHAN_LSB +: 2]     = rx_chan_r;
        rd_word[`IPL_RX_KIND_BIT]          = rx_stream_r;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= i_rd ? rd_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(ack_rcv_r & write_ack_irq_enable_r) | |(toe_r & toe_ie_r);
    end
  end

endmodule

// ===== ipl_defs.svh
// Register map, field positions, reset values and timing counts of the link
`ifndef IPL_DEFS_SVH
`define IPL_DEFS_SVH

// Register byte offsets on the plain register port
`define IPL_REG_CMD      8'h00
`define IPL_REG_TXDATA   8'h04
`define IPL_REG_STATUS   8'h08
`define IPL_REG_ERROR    8'h0c
`define IPL_REG_IRQEN    8'h10
`define IPL_REG_RXDATA   8'h14

// channel_command_reg fields
`define IPL_CMD_WRT_LSB    0
`define IPL_CMD_ST_LSB     4
`define IPL_CMD_PEND_BIT   8
`define IPL_CMD_TOKEN_BIT  9
`define IPL_CMD_WAIT_BIT   10

// channel_irq_enable_reg fields
`define IPL_IRQEN_WRITE_ACK_IRQ_ENABLE_LSB 0
`define IPL_IRQEN_TOE_LSB  4

// rx data register fields
`define IPL_RX_CHAN_LSB    8
`define IPL_RX_KIND_BIT    10

// Reset values
`define IPL_TXDATA_RST   8'h00
`define IPL_IRQEN_RST    4'h0

// Ack wait before a channel timeout error, in clock cycles
`define IPL_ACK_TIMEOUT_CYC 1024
`define IPL_TMO_W           16
`define IPL_CHAN_MAX        4

`endif

// ===== ipl_pkg.sv
// Types shared by both ends of the inter-processor link
package ipl_pkg;

  typedef enum logic [1:0] {
    FK_WRITE   = 2'b00,
    FK_STREAM  = 2'b01,
    FK_ACK     = 2'b10,
    FK_TRIGGER = 2'b11
  } frame_kind_e;

  typedef enum logic [1:0] {
    S_NO_TOKEN = 2'b00,
    S_HOLD     = 2'b01,
    S_WAIT_ACK = 2'b10
  } node_state_e;

endpackage

// ===== ipl_link_if.sv
// Frame-level link joining the device end and the peer end
`timescale 1ns/1ps
interface ipl_link_if;
  logic                   d2p_valid;
  ipl_pkg::frame_kind_e   d2p_kind;
  logic [1:0]             d2p_chan;
  logic [7:0]             d2p_data;
  logic                   p2d_valid;
  ipl_pkg::frame_kind_e   p2d_kind;
  logic [1:0]             p2d_chan;
  logic [7:0]             p2d_data;

  modport dev (
    output d2p_valid, d2p_kind, d2p_chan, d2p_data,
    input  p2d_valid, p2d_kind, p2d_chan, p2d_data
  );

  modport peer (
    input  d2p_valid, d2p_kind, d2p_chan, d2p_data,
    output p2d_valid, p2d_kind, p2d_chan, p2d_data
  );
endinterface

// ===== ipl_peer_end.sv
// Peer node: target of device writes and token-passing initiator of its own
`timescale 1ns/1ps
`include "ipl_defs.svh"
module ipl_peer_end #(
  parameter int ACK_TIMEOUT = `IPL_ACK_TIMEOUT_CYC,
  parameter bit INIT_TOKEN  = 1'b0
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  // Write request from the peer user
  input  wire logic        i_req_valid,
  input  wire logic        i_req_stream,
  input  wire logic [1:0]  i_req_chan,
  input  wire logic [7:0]  i_req_data,
  output logic             o_req_ready,
  // Frames received from the device
  output logic             o_rx_valid,
  output logic             o_rx_stream,
  output logic [1:0]       o_rx_chan,
  output logic [7:0]       o_rx_data,
  // Status
  output logic             o_ack_done,
  output logic             o_timeout,
  output logic             o_has_token,
  // Link
  ipl_link_if.peer         link
);

  if (ACK_TIMEOUT < 2 || ACK_TIMEOUT >= (1 << `IPL_TMO_W)) begin : g_chk
    $error("ipl_peer_end: ACK_TIMEOUT out of range");
  end

  ipl_pkg::node_state_e  state_r;
  ipl_pkg::node_state_e  state_nxt;
  logic                  pend_r;
  logic                  pend_stream_r;
  logic [1:0]            pend_chan_r;
  logic [7:0]            pend_data_r;
  logic [1:0]            out_chan_r;
  logic [`IPL_TMO_W-1:0] tmo_cnt_r;
  logic                  tx_valid_nxt;
  ipl_pkg::frame_kind_e  tx_kind_nxt;
  logic [1:0]            tx_chan_nxt;
  logic [7:0]            tx_data_nxt;
  logic                  send_req;
  logic                  ack_evt;
  logic                  tmo_evt;
  logic                  rx_wr;
  logic                  rx_trig;
  logic                  rx_ack;

  assign rx_wr   = link.d2p_valid && (link.d2p_kind == ipl_pkg::FK_WRITE ||
                                      link.d2p_kind == ipl_pkg::FK_STREAM);
  assign rx_trig = link.d2p_valid && link.d2p_kind == ipl_pkg::FK_TRIGGER;
  assign rx_ack  = link.d2p_valid && link.d2p_kind == ipl_pkg::FK_ACK;

  // One request held at a time; no new one until its ack is back or it times out
  assign o_req_ready = !pend_r;

  always_comb begin
    state_nxt    = state_r;
    tx_valid_nxt = 1'b0;
    tx_kind_nxt  = ipl_pkg::FK_TRIGGER;
    tx_chan_nxt  = 2'h0;
    tx_data_nxt  = 8'h00;
    send_req     = 1'b0;
    ack_evt      = 1'b0;
    tmo_evt      = 1'b0;
    if (rx_wr) begin
      tx_valid_nxt = 1'b1;
      tx_kind_nxt  = ipl_pkg::FK_ACK;
      tx_chan_nxt  = link.d2p_chan;
    end else begin
      case (state_r)
        ipl_pkg::S_HOLD, ipl_pkg::S_NO_TOKEN: begin
          // Start only while holding the token, never over a device write
          if (state_r == ipl_pkg::S_HOLD || rx_trig) begin
            tx_valid_nxt = 1'b1;
            if (pend_r) begin
              tx_kind_nxt = pend_stream_r ? ipl_pkg::FK_STREAM
                                          : ipl_pkg::FK_WRITE;
              tx_chan_nxt = pend_chan_r;
              tx_data_nxt = pend_data_r;
              send_req    = 1'b1;
              state_nxt   = ipl_pkg::S_WAIT_ACK;
            end else begin
              state_nxt   = ipl_pkg::S_NO_TOKEN;
            end
          end
        end
        ipl_pkg::S_WAIT_ACK: begin
          if (rx_ack && link.d2p_chan == out_chan_r) begin
            ack_evt      = 1'b1;
            tx_valid_nxt = 1'b1;
            state_nxt    = ipl_pkg::S_NO_TOKEN;
          end else if (tmo_cnt_r == `IPL_TMO_W'(ACK_TIMEOUT - 1)) begin
            tmo_evt      = 1'b1;
            tx_valid_nxt = 1'b1;
            state_nxt    = ipl_pkg::S_NO_TOKEN;
          end
        end
        default: state_nxt = ipl_pkg::S_NO_TOKEN;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_r <= INIT_TOKEN ? ipl_pkg::S_HOLD : ipl_pkg::S_NO_TOKEN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      pend_r        <= 1'b0;
      pend_stream_r <= 1'b0;
      pend_chan_r   <= 2'h0;
      pend_data_r   <= 8'h00;
      out_chan_r    <= 2'h0;
    end else begin
      if (send_req) begin
        out_chan_r <= pend_chan_r;
      end
      if (ack_evt || tmo_evt) begin
        pend_r <= 1'b0;
      end else if (i_req_valid && !pend_r) begin
        pend_r        <= 1'b1;
        pend_stream_r <= i_req_stream;
        pend_chan_r   <= i_req_chan;
        pend_data_r   <= i_req_data;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst || state_r != ipl_pkg::S_WAIT_ACK) begin
      tmo_cnt_r <= '0;
    end else begin
      tmo_cnt_r <= tmo_cnt_r + `IPL_TMO_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      link.p2d_valid <= 1'b0;
      link.p2d_kind  <= ipl_pkg::FK_TRIGGER;
      link.p2d_chan  <= 2'h0;
      link.p2d_data  <= 8'h00;
      o_rx_valid     <= 1'b0;
      o_rx_stream    <= 1'b0;
      o_rx_chan      <= 2'h0;
      o_rx_data      <= 8'h00;
      o_ack_done     <= 1'b0;
      o_timeout      <= 1'b0;
    end else begin
      link.p2d_valid <= tx_valid_nxt;
      link.p2d_kind  <= tx_kind_nxt;
      link.p2d_chan  <= tx_chan_nxt;
      link.p2d_data  <= tx_data_nxt;
      o_rx_valid     <= rx_wr;
      o_ack_done     <= ack_evt;
      o_timeout      <= tmo_evt;
      if (rx_wr) begin
        o_rx_stream <= link.d2p_kind == ipl_pkg::FK_STREAM;
        o_rx_chan   <= link.d2p_chan;
        o_rx_data   <= link.d2p_data;
      end
    end
  end

  assign o_has_token = state_r != ipl_pkg::S_NO_TOKEN;

endmodule

// ===== ipl_link_assertions.sv
// Frame-level checks on the link between the two ends
`timescale 1ns/1ps
module ipl_link_assertions (
  // Clock and reset
  input wire logic                 i_clk_sys,
  input wire logic                 i_srst,
  // Device to peer
  input wire logic                 d2p_valid,
  input wire ipl_pkg::frame_kind_e d2p_kind,
  input wire logic [1:0]           d2p_chan,
  input wire logic [7:0]           d2p_data,
  // Peer to device
  input wire logic                 p2d_valid,
  input wire ipl_pkg::frame_kind_e p2d_kind,
  input wire logic [1:0]           p2d_chan,
  input wire logic [7:0]           p2d_data
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  logic d_wr;
  logic p_wr;
  logic d_ack;
  logic p_ack;
  logic d_trg;
  logic p_trg;

  // Kind bit 1 low marks write and stream frames
  assign d_wr  = d2p_valid && !d2p_kind[1];
  assign p_wr  = p2d_valid && !p2d_kind[1];
  assign d_ack = d2p_valid && d2p_kind == ipl_pkg::FK_ACK;
  assign p_ack = p2d_valid && p2d_kind == ipl_pkg::FK_ACK;
  assign d_trg = d2p_valid && d2p_kind == ipl_pkg::FK_TRIGGER;
  assign p_trg = p2d_valid && p2d_kind == ipl_pkg::FK_TRIGGER;

  sequence s_peer_ack;
    p_ack && p2d_chan == $past(d2p_chan);
  endsequence
  sequence s_dev_ack;
    d_ack && d2p_chan == $past(p2d_chan);
  endsequence

  dev_write_a: assert property (d_wr |=> s_peer_ack ##1 d_trg)
    else $error("device write not closed by ack then token return");
  peer_write_a: assert property (p_wr |=> s_dev_ack ##1 p_trg)
    else $error("peer write not closed by ack then token return");
  ack_cause_a: assert property (d_ack |-> $past(p_wr))
    else $error("device ack without a peer write");
  target_quiet_a: assert property (d_wr |=> !p_wr [*2])
    else $error("peer wrote during a device transfer");
  no_clash_a: assert property (!(d2p_valid && p2d_valid))
    else $error("both ends sent frames in one cycle");
  dev_turn_a: assert property (
    p_trg |=> d2p_valid && d2p_kind != ipl_pkg::FK_ACK)
    else $error("device did not use or return the token");
  peer_turn_a: assert property (
    d_trg |=> p2d_valid && p2d_kind != ipl_pkg::FK_ACK)
    else $error("peer did not use or return the token");
  trig_clean_a: assert property (d_trg |-> d2p_chan == 0 && d2p_data == 0)
    else $error("device trigger frame carries channel or data");
endmodule

// ===== interprocessor_write_link_control_test.sv
// Bench joining device and peer ends, with a queue model of frames
`timescale 1ns/1ps
`include "ipl_defs.svh"
module interprocessor_write_link_control_test;
  localparam int TMO = 16;
  logic        clk;
  logic        srst;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        irq;
  logic        rq_v;
  logic        rq_s;
  logic [1:0]  rq_c;
  logic [7:0]  rq_d;
  logic        rq_rdy;
  logic        rx_v;
  logic        rx_s;
  logic [1:0]  rx_c;
  logic [7:0]  rx_d;
  logic        ack_done;
  logic        tmo;
  logic        tok;
  int          fails = 0;
  int          checked = 0;
  int          cyc = 0;
  int          acks = 0;
  int          seed;
  int          n;
  int          a0;
  int          ch;
  logic [31:0] v;
  logic [31:0] m;
  logic [10:0] exp_q[$];

  ipl_link_if ipl_link_if_inst ();
  ipl_dev_end #(.ACK_TIMEOUT(TMO)) ipl_dev_end_inst (
    .i_clk_sys(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq),
    .link(ipl_link_if_inst.dev));
  ipl_peer_end #(.ACK_TIMEOUT(TMO)) ipl_peer_end_inst (
    .i_clk_sys(clk), .i_srst(srst), .i_req_valid(rq_v),
    .i_req_stream(rq_s), .i_req_chan(rq_c), .i_req_data(rq_d),
    .o_req_ready(rq_rdy), .o_rx_valid(rx_v), .o_rx_stream(rx_s),
    .o_rx_chan(rx_c), .o_rx_data(rx_d), .o_ack_done(ack_done),
    .o_timeout(tmo), .o_has_token(tok), .link(ipl_link_if_inst.peer));
  ipl_link_assertions ipl_link_assertions_inst (
    .i_clk_sys(clk), .i_srst(srst),
    .d2p_valid(ipl_link_if_inst.d2p_valid),
    .d2p_kind(ipl_link_if_inst.d2p_kind),
    .d2p_chan(ipl_link_if_inst.d2p_chan),
    .d2p_data(ipl_link_if_inst.d2p_data),
    .p2d_valid(ipl_link_if_inst.p2d_valid),
    .p2d_kind(ipl_link_if_inst.p2d_kind),
    .p2d_chan(ipl_link_if_inst.p2d_chan),
    .p2d_data(ipl_link_if_inst.p2d_data));

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  // Poll until nothing is queued and no ack is outstanding
  task automatic drain();
    logic [31:0] c;
    for (n = 0; n < 40; n++) begin
      reg_rd(`IPL_REG_CMD, c);
      if ((c & 32'h500) === 32'h0) break;
    end
    check("dev_idle", c & 32'h500, 32'h0);
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Model side: every write or stream frame seen at the peer must match the queue head
  always @(posedge clk) begin
    cyc++;
    if (ack_done === 1'b1) acks++;
    if (ack_done === 1'b1) check("peer_token", tok, 1'b0);
    if (tmo === 1'b1) check("peer_timeout", 1, 0);
    if (rx_v === 1'b1) begin
      if (exp_q.size() == 0) check("rx_extra", 1, 0);
      else check("rx_frame", {rx_s, rx_c, rx_d}, exp_q.pop_front());
    end
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    seed  = 32'h1acd939e;
    srst  = 1'b1;
    {wr, rd, addr, wdata} = '0;
    {rq_v, rq_s, rq_c, rq_d} = '0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    reg_wr(8'h18, 32'hff);
    reg_rd(8'h18, v);
    check("unmapped", v, 32'h0);
    reg_rd(`IPL_REG_TXDATA, v);
    check("txdata_rst", v, 32'h0);
    reg_rd(`IPL_REG_IRQEN, v);
    check("irqen_rst", v, 32'h0);
    // Every channel, write then stream, random interrupt mask
    for (int i = 0; i < 8; i++) begin
      ch = i % 4;
      m  = $random(seed) & 32'hf;
      v  = $random(seed) & 32'hff;
      reg_wr(`IPL_REG_IRQEN, m);
      reg_wr(`IPL_REG_TXDATA, v);
      exp_q.push_back({i >= 4, ch[1:0], v[7:0]});
      reg_wr(`IPL_REG_CMD, 32'h1 << (ch + 4 * (i / 4)));
      drain();
      repeat (2) @(posedge clk);
      check("irq_ack", irq, m[ch]);
      reg_rd(`IPL_REG_STATUS, v);
      check("ack_received", v, 32'h1 << ch);
      // Interrupt is registered, so it falls one cycle after the clear
      @(posedge clk);
      #1;
      check("irq_clear", irq, 1'b0);
    end
    // Two channels at once, then a stream start over a pending ack
    v = $random(seed) & 32'hff;
    reg_wr(`IPL_REG_TXDATA, v);
    exp_q.push_back({1'b0, 2'd0, v[7:0]});
    reg_wr(`IPL_REG_IRQEN, 32'h60);
    reg_wr(`IPL_REG_CMD, 32'h5);
    reg_wr(`IPL_REG_CMD, 32'h20);
    drain();
    repeat (2) @(posedge clk);
    check("irq_err", irq, 1'b1);
    reg_rd(`IPL_REG_ERROR, v);
    check("timeout_err", v, 32'h6);
    reg_rd(`IPL_REG_STATUS, v);
    check("first_acked", v, 32'h1);
    check("irq_err_clr", irq, 1'b0);
    // Peer writes, every other one racing a device write
    for (int i = 0; i < 8; i++) begin
      v  = $random(seed);
      a0 = acks;
      check("req_ready", rq_rdy, 1'b1);
      @(posedge clk);
      rq_v <= 1'b1;
      rq_s <= v[8];
      rq_c <= v[10:9];
      rq_d <= v[7:0];
      @(posedge clk);
      rq_v <= 1'b0;
      if (i % 2 == 1) begin
        reg_wr(`IPL_REG_TXDATA, {24'h0, v[23:16]});
        exp_q.push_back({1'b0, v[12:11], v[23:16]});
        reg_wr(`IPL_REG_CMD, 32'h1 << v[12:11]);
      end
      for (n = 0; n < 60 && acks == a0; n++) @(posedge clk);
      check("peer_ack", acks, a0 + 1);
      drain();
      reg_rd(`IPL_REG_RXDATA, m);
      check("rx_at_dev", m[10:0], {v[8], v[10:9], v[7:0]});
      reg_rd(`IPL_REG_STATUS, m);
      check("dev_status", m, i % 2 ? 32'h1 << v[12:11] : 0);
    end
    check("queue_empty", exp_q.size(), 0);
    end_of_test();
  end
endmodule
